// ===== hdl/agm_pkg.sv
/*
  package for the address generation block: register offsets, control field
  positions, reset values and encodings of addressing modes and requests.
  assumes it is compiled before the design module.
*/
package agm_pkg;
  localparam logic [7:0] AGM_OFS_CONTROL = 8'h00;
  localparam logic [7:0] AGM_OFS_X_START = 8'h04;
  localparam logic [7:0] AGM_OFS_X_END = 8'h08;
  localparam logic [7:0] AGM_OFS_Y_START = 8'h0c;
  localparam logic [7:0] AGM_OFS_Y_END = 8'h10;
  localparam logic [7:0] AGM_OFS_REV_CTRL = 8'h14;
  localparam logic [7:0] AGM_OFS_STATUS = 8'h18;
  localparam int AGM_XSEL_LSB = 0;
  localparam int AGM_YSEL_LSB = 4;
  localparam int AGM_REVSEL_LSB = 8;
  localparam int AGM_YEN_BIT = 14;
  localparam int AGM_XEN_BIT = 15;
  localparam int AGM_REVEN_BIT = 15;
  localparam logic [3:0] AGM_SEL_NONE = 4'hf;
  localparam logic [15:0] AGM_CONTROL_RST = 16'h0000;
  localparam logic [15:0] AGM_START_RST = 16'h0000;
  localparam logic [15:0] AGM_END_RST = 16'h0001;
  localparam logic [15:0] AGM_REV_RST = 16'h0000;
  localparam logic [15:0] AGM_CONTROL_MASK = 16'hcfff;
  localparam logic [12:0] AGM_NEAR_MASK = 13'h1fff;
  localparam logic [15:0] AGM_WORD_MASK = 16'hfffe;
  // addressing modes of one address request
  typedef enum logic [2:0] {
    AGM_MODE_DIRECT = 3'd0,
    AGM_MODE_IND = 3'd1,
    AGM_MODE_POST = 3'd2,
    AGM_MODE_PRE = 3'd3,
    AGM_MODE_REGOFS = 3'd4,
    AGM_MODE_LITOFS = 3'd5,
    AGM_MODE_FILE = 3'd6
  } agm_mode_t;
  // instruction class of a request
  typedef enum logic [1:0] {
    AGM_CLS_MCU = 2'd0,
    AGM_CLS_MOVE = 2'd1,
    AGM_CLS_MAC = 2'd2
  } agm_cls_t;
  // bus slave states, one-hot
  typedef enum logic [1:0] {
    AGM_BUS_IDLE = 2'b01,
    AGM_BUS_DATA = 2'b10
  } agm_bus_t;
endpackage

// ===== hdl/agm_address_generation_modulo.sv
/*
  address generation with circular buffer correction: one X read unit, one X
  write unit and one Y read unit, each taking a registered request and giving
  a registered address and pointer write-back one cycle later; the circular
  and reversed-order controls sit behind an AHB-Lite slave.
  assumes decode supplies pointer and offset values read from the working
  registers, and that the register file writes back on *_wb_valid.
*/
// Decided for this implementation: the register offsets and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
module agm_address_generation_modulo
  import agm_pkg::*;
#(
  parameter int AW = 16
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // X read request
  input wire logic xr_valid,
  input wire agm_pkg::agm_cls_t xr_cls,
  input wire agm_pkg::agm_mode_t xr_mode,
  input wire logic [3:0] xr_ptr_sel,
  input wire logic [AW-1:0] xr_ptr,
  input wire logic [AW-1:0] xr_ofs,
  input wire logic [12:0] xr_file,
  // X write request
  input wire logic xw_valid,
  input wire agm_pkg::agm_cls_t xw_cls,
  input wire agm_pkg::agm_mode_t xw_mode,
  input wire logic [3:0] xw_ptr_sel,
  input wire logic [AW-1:0] xw_ptr,
  input wire logic [AW-1:0] xw_ofs,
  input wire logic [12:0] xw_file,
  input wire logic xw_word,
  // Y read request (MAC only)
  input wire logic yr_valid,
  input wire agm_pkg::agm_cls_t yr_cls,
  input wire agm_pkg::agm_mode_t yr_mode,
  input wire logic [3:0] yr_ptr_sel,
  input wire logic [AW-1:0] yr_ptr,
  input wire logic [AW-1:0] yr_ofs,
  // results
  output logic xr_addr_valid,
  output logic [AW-1:0] xr_addr,
  output logic xr_wb_valid,
  output logic [3:0] xr_wb_sel,
  output logic [AW-1:0] xr_wb_data,
  output logic xw_addr_valid,
  output logic [AW-1:0] xw_addr,
  output logic xw_wb_valid,
  output logic [3:0] xw_wb_sel,
  output logic [AW-1:0] xw_wb_data,
  output logic yr_addr_valid,
  output logic [AW-1:0] yr_addr,
  output logic yr_wb_valid,
  output logic [3:0] yr_wb_sel,
  output logic [AW-1:0] yr_wb_data,
  output logic req_error
);
  import agm_pkg::*;

  logic [15:0] control_r;
  logic [15:0] x_start_r;
  logic [15:0] x_end_r;
  logic [15:0] y_start_r;
  logic [15:0] y_end_r;
  logic [15:0] rev_r;
  logic [1:0] err_r;

  // unit 0 = X read, 1 = X write, 2 = Y read
  logic [2:0] u_valid;
  agm_cls_t u_cls [3];
  agm_mode_t u_mode [3];
  logic [3:0] u_sel [3];
  logic [AW-1:0] u_ptr [3];
  logic [AW-1:0] u_ofs [3];
  logic [12:0] u_file [3];
  logic [AW-1:0] u_start [3];
  logic [AW-1:0] u_end [3];
  logic [2:0] u_circ;
  logic [2:0] u_bad;
  logic [AW-1:0] u_ea [3];
  logic [2:0] u_wb;
  logic [AW-1:0] u_wbd [3];

  assign u_valid = {yr_valid, xw_valid, xr_valid};
  assign u_cls[0] = xr_cls;
  assign u_cls[1] = xw_cls;
  assign u_cls[2] = yr_cls;
  assign u_mode[0] = xr_mode;
  assign u_mode[1] = xw_mode;
  assign u_mode[2] = yr_mode;
  assign u_sel[0] = xr_ptr_sel;
  assign u_sel[1] = xw_ptr_sel;
  assign u_sel[2] = yr_ptr_sel;
  assign u_ptr[0] = xr_ptr;
  assign u_ptr[1] = xw_ptr;
  assign u_ptr[2] = yr_ptr;
  assign u_ofs[0] = xr_ofs;
  assign u_ofs[1] = xw_ofs;
  assign u_ofs[2] = yr_ofs;
  assign u_file[0] = xr_file;
  assign u_file[1] = xw_file;
  assign u_file[2] = 13'h0000;
  // X buffer also serves the X write unit; one buffer per space
  assign u_start[0] = x_start_r;
  assign u_start[1] = x_start_r;
  assign u_start[2] = y_start_r;
  assign u_end[0] = x_end_r;
  assign u_end[1] = x_end_r;
  assign u_end[2] = y_end_r;

  wire [3:0] x_pointer_select = control_r[AGM_XSEL_LSB +: 4];
  wire [3:0] y_pointer_select = control_r[AGM_YSEL_LSB +: 4];
  wire x_circular_enable = control_r[AGM_XEN_BIT];
  wire y_circular_enable = control_r[AGM_YEN_BIT];
  wire x_circ_on = x_circular_enable && (x_pointer_select != AGM_SEL_NONE);
  wire y_circ_on = y_circular_enable && (y_pointer_select != AGM_SEL_NONE);
  wire [3:0] rev_sel = control_r[AGM_REVSEL_LSB +: 4];
  // reversed order only on data writes, so only the X write unit sees it
  wire rev_on = rev_r[AGM_REVEN_BIT] && (rev_sel != AGM_SEL_NONE);
  wire xw_rev = rev_on && xw_word && (xw_ptr_sel == rev_sel) &&
                (xw_mode == AGM_MODE_POST || xw_mode == AGM_MODE_PRE);
  wire [AW-1:0] rev_mod = AW'({rev_r[14:0], 1'b0});
  wire [AW-1:0] ptr_rev;
  wire [AW-1:0] mod_rev;
  wire [AW-1:0] sum_rev;
  wire [AW-1:0] rev_ea;
  // carry runs toward the low bits: mirror, add, mirror back
  genvar b;
  generate
    for (b = 0; b < AW; b++) begin : g_mirror
      assign ptr_rev[b] = xw_ptr[AW-1-b];
      assign mod_rev[b] = rev_mod[AW-1-b];
      assign rev_ea[b] = sum_rev[AW-1-b];
    end
  endgenerate
  assign sum_rev = ptr_rev + mod_rev;

  assign u_circ[0] = x_circ_on && (xr_ptr_sel == x_pointer_select);
  assign u_circ[1] = x_circ_on && (xw_ptr_sel == x_pointer_select) && !xw_rev;
  assign u_circ[2] = y_circ_on && (yr_ptr_sel == y_pointer_select);

  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_unit
      logic [AW-1:0] raw;
      logic [AW-1:0] stepped;
      logic [AW-1:0] fixed;
      logic [AW-1:0] blen;
      logic is_mac;
      logic mac_ok;
      // result registers kept per unit so each has a single process driving it
      logic av_r;
      logic wbv_r;
      logic [AW-1:0] addr_r;
      logic [AW-1:0] wbd_r;
      logic [3:0] sel_r;
      assign is_mac = (u_cls[g] == AGM_CLS_MAC);
      // plain indirect, indexed on 9/11 only, post by 2/4/6
      assign mac_ok = (g == 1) ? 1'b0 :
        (u_sel[g] == ((g == 0) ? 4'd8 : 4'd10) || u_sel[g] == ((g == 0) ? 4'd9 : 4'd11)) &&
        (u_mode[g] == AGM_MODE_IND ||
         (u_mode[g] == AGM_MODE_REGOFS && u_sel[g] == ((g == 0) ? 4'd9 : 4'd11)) ||
         (u_mode[g] == AGM_MODE_POST && (u_ofs[g] == AW'(2) || u_ofs[g] == AW'(4) ||
          u_ofs[g] == AW'(6))));
      // Y unit serves only MAC reads; X units refuse direct mode as a memory access
      assign u_bad[g] = u_valid[g] && (is_mac ? !mac_ok : (g == 2 || u_mode[g] == AGM_MODE_DIRECT));
      assign stepped = u_ptr[g] + u_ofs[g];
      assign blen = u_end[g] - u_start[g] + AW'(1);
      // magnitude checks on both bounds, one correction only, so steps up to one buffer length wrap
      assign fixed = (stepped > u_end[g]) ? stepped - blen :
                     (stepped < u_start[g]) ? stepped + blen : stepped;
      always_comb begin
        raw = stepped;
        case (u_mode[g])
          AGM_MODE_IND, AGM_MODE_POST: raw = u_ptr[g];
          AGM_MODE_PRE: raw = u_circ[g] ? fixed : stepped;
          AGM_MODE_REGOFS, AGM_MODE_LITOFS: raw = u_circ[g] ? fixed : stepped;
          // move form takes a full-width address, others the near field
          AGM_MODE_FILE: raw = (u_cls[g] == AGM_CLS_MOVE) ? u_ofs[g] : AW'(u_file[g] & AGM_NEAR_MASK);
          default: raw = u_ptr[g];
        endcase
        // post-modify still addresses through the old pointer
        if (g == 1 && xw_rev && u_mode[g] == AGM_MODE_PRE) begin
          raw = rev_ea & AGM_WORD_MASK;
        end
      end
      assign u_ea[g] = (g == 2 || is_mac) ? (raw & AGM_WORD_MASK) : raw;
      // only modifying modes write back; offsets leave the pointer alone
      assign u_wb[g] = u_valid[g] && !u_bad[g] &&
                       (u_mode[g] == AGM_MODE_POST || u_mode[g] == AGM_MODE_PRE);
      assign u_wbd[g] = (g == 1 && xw_rev) ? rev_ea : (u_circ[g] ? fixed : stepped);

      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          av_r <= 1'b0;
          wbv_r <= 1'b0;
          addr_r <= '0;
          wbd_r <= '0;
          sel_r <= 4'h0;
        end else begin
          av_r <= u_valid[g] && !u_bad[g] && (u_mode[g] != AGM_MODE_DIRECT);
          wbv_r <= u_wb[g];
          addr_r <= u_ea[g];
          wbd_r <= u_wbd[g];
          sel_r <= u_sel[g];
        end
      end
    end
  endgenerate

  assign xr_addr_valid = g_unit[0].av_r;
  assign xr_addr = g_unit[0].addr_r;
  assign xr_wb_valid = g_unit[0].wbv_r;
  assign xr_wb_sel = g_unit[0].sel_r;
  assign xr_wb_data = g_unit[0].wbd_r;
  assign xw_addr_valid = g_unit[1].av_r;
  assign xw_addr = g_unit[1].addr_r;
  assign xw_wb_valid = g_unit[1].wbv_r;
  assign xw_wb_sel = g_unit[1].sel_r;
  assign xw_wb_data = g_unit[1].wbd_r;
  assign yr_addr_valid = g_unit[2].av_r;
  assign yr_addr = g_unit[2].addr_r;
  assign yr_wb_valid = g_unit[2].wbv_r;
  assign yr_wb_sel = g_unit[2].sel_r;
  assign yr_wb_data = g_unit[2].wbd_r;

  // bus slave: zero wait states, always OKAY
  agm_bus_t bus_r;
  logic [7:0] wadr_r;
  logic wr_r;
  logic err_any_r;
  wire take = hsel && hready && htrans[1];
  wire [7:0] rd_adr = haddr[7:0];
  wire [15:0] wd = hwdata[15:0];
  wire do_wr = (bus_r == AGM_BUS_DATA) && wr_r;
  wire [15:0] rd_val =
    (rd_adr == AGM_OFS_CONTROL) ? control_r :
    (rd_adr == AGM_OFS_X_START) ? x_start_r :
    (rd_adr == AGM_OFS_X_END) ? x_end_r :
    (rd_adr == AGM_OFS_Y_START) ? y_start_r :
    (rd_adr == AGM_OFS_Y_END) ? y_end_r :
    (rd_adr == AGM_OFS_REV_CTRL) ? rev_r :
    (rd_adr == AGM_OFS_STATUS) ? {13'h0000, err_r, err_any_r} : 16'h0000;
  // reading status clears the sticky error bits; a new error wins
  wire st_rd = take && !hwrite && (rd_adr == AGM_OFS_STATUS);
  wire new_err = |u_bad;
  // write strobes, one per register except status; status and unmapped offsets simply store nothing
  wire wr_control = do_wr && (wadr_r == AGM_OFS_CONTROL);
  wire wr_x_start = do_wr && (wadr_r == AGM_OFS_X_START);
  wire wr_x_end = do_wr && (wadr_r == AGM_OFS_X_END);
  wire wr_y_start = do_wr && (wadr_r == AGM_OFS_Y_START);
  wire wr_y_end = do_wr && (wadr_r == AGM_OFS_Y_END);
  wire wr_rev = do_wr && (wadr_r == AGM_OFS_REV_CTRL);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bus_r <= AGM_BUS_IDLE;
      wadr_r <= 8'h00;
      wr_r <= 1'b0;
      hrdata <= 32'h0000_0000;
    end else begin
      bus_r <= take ? AGM_BUS_DATA : AGM_BUS_IDLE;
      wadr_r <= rd_adr;
      wr_r <= take && hwrite;
      hrdata <= (take && !hwrite) ? {16'h0000, rd_val} : 32'h0000_0000;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      control_r <= AGM_CONTROL_RST;
    end else if (wr_control) begin
      control_r <= wd & AGM_CONTROL_MASK;
    end
  end

  // start forced even, end forced odd, so the length is always whole words
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      x_start_r <= AGM_START_RST;
    end else if (wr_x_start) begin
      x_start_r <= wd & AGM_WORD_MASK;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      x_end_r <= AGM_END_RST;
    end else if (wr_x_end) begin
      x_end_r <= wd | ~AGM_WORD_MASK;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      y_start_r <= AGM_START_RST;
    end else if (wr_y_start) begin
      y_start_r <= wd & AGM_WORD_MASK;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      y_end_r <= AGM_END_RST;
    end else if (wr_y_end) begin
      y_end_r <= wd | ~AGM_WORD_MASK;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rev_r <= AGM_REV_RST;
    end else if (wr_rev) begin
      rev_r <= wd;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      err_r <= 2'b00;
      err_any_r <= 1'b0;
    end else begin
      err_r <= {u_bad[2], u_bad[0] | u_bad[1]} | (st_rd ? 2'b00 : err_r);
      err_any_r <= new_err | (st_rd ? 1'b0 : err_any_r);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      req_error <= 1'b0;
    end else begin
      req_error <= new_err;
    end
  end

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
endmodule

// ===== tb/agm_regfile_model.sv
/*
  far-side working register model: keeps the pointers written back by the
  three units and shows the one named by xr_ptr_sel.
  assumes no two units write one register in the same cycle.
*/
`timescale 1ns/1ps
module agm_regfile_model (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic xr_wb_valid,
  input wire logic [3:0] xr_wb_sel,
  input wire logic [15:0] xr_wb_data,
  input wire logic xw_wb_valid,
  input wire logic [3:0] xw_wb_sel,
  input wire logic [15:0] xw_wb_data,
  input wire logic yr_wb_valid,
  input wire logic [3:0] yr_wb_sel,
  input wire logic [15:0] yr_wb_data,
  input wire logic [3:0] xr_ptr_sel,
  output logic [15:0] xr_rval
);
  logic [15:0] w_r [16];
  assign xr_rval = w_r[xr_ptr_sel];
  // pointers move only on write-back pulses
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      w_r <= '{default: '0};
    end else begin
      if (xr_wb_valid) w_r[xr_wb_sel] <= xr_wb_data;
      if (xw_wb_valid) w_r[xw_wb_sel] <= xw_wb_data;
      if (yr_wb_valid) w_r[yr_wb_sel] <= yr_wb_data;
    end
  end
endmodule

// ===== tb/agm_checker_properties.sv
/*
  assertions on request and result ports of the address block.
  assumes one clock domain and a bind to the top module by port name.
*/
`timescale 1ns/1ps
module agm_checker
  import agm_pkg::*;
#(
  parameter int AW = 16
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic xr_valid,
  input wire agm_pkg::agm_cls_t xr_cls,
  input wire agm_pkg::agm_mode_t xr_mode,
  input wire logic [3:0] xr_ptr_sel,
  input wire logic [AW-1:0] xr_ptr,
  input wire logic [AW-1:0] xr_ofs,
  input wire logic [12:0] xr_file,
  input wire logic yr_valid,
  input wire agm_pkg::agm_cls_t yr_cls,
  input wire logic [3:0] yr_ptr_sel,
  input wire logic [AW-1:0] xr_addr,
  input wire logic xr_wb_valid,
  input wire logic [AW-1:0] xr_wb_data,
  input wire logic yr_addr_valid,
  input wire logic [AW-1:0] yr_addr,
  input wire logic req_error
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  wire mcu = xr_valid && xr_cls == AGM_CLS_MCU;
  // select 15 is never the circular pointer, so results stay uncorrected
  wire m15 = xr_valid && xr_cls != AGM_CLS_MAC && xr_ptr_sel == AGM_SEL_NONE;
  wire xmac = xr_valid && xr_cls == AGM_CLS_MAC;
  property p_post; mcu && xr_mode == AGM_MODE_POST |=> xr_addr == $past(xr_ptr); endproperty
  a_post: assert property (p_post) else $error("post address not old pointer");
  property p_pre; m15 && xr_mode == AGM_MODE_PRE |=> xr_wb_valid && xr_addr == xr_wb_data
    && xr_addr == AW'($past(xr_ptr) + $past(xr_ofs)); endproperty
  a_pre: assert property (p_pre) else $error("pre address wrong");
  property p_idx; m15 && xr_cls == AGM_CLS_MOVE && xr_mode == AGM_MODE_REGOFS
    |=> xr_addr == AW'($past(xr_ptr) + $past(xr_ofs)); endproperty
  a_idx: assert property (p_idx) else $error("indexed address wrong");
  property p_nowb; xr_valid && xr_mode inside {AGM_MODE_REGOFS, AGM_MODE_LITOFS} |=> !xr_wb_valid; endproperty
  a_nowb: assert property (p_nowb) else $error("offset mode wrote pointer");
  property p_file; mcu && xr_mode == AGM_MODE_FILE |=> xr_addr == {3'b000, $past(xr_file)}; endproperty
  a_file: assert property (p_file) else $error("file address wrong");
  property p_ynon; yr_valid && yr_cls != AGM_CLS_MAC |=> req_error && !yr_addr_valid; endproperty
  a_ynon: assert property (p_ynon) else $error("y unit took non mac");
  property p_yreg; yr_valid && !(yr_ptr_sel inside {4'ha, 4'hb}) |=> req_error && !yr_addr_valid; endproperty
  a_yreg: assert property (p_yreg) else $error("y unit took wrong register");
  property p_mstep; xmac && xr_mode == AGM_MODE_POST && !(xr_ofs inside {2, 4, 6}) |=> req_error; endproperty
  a_mstep: assert property (p_mstep) else $error("mac step accepted");
  property p_midx; xmac && xr_mode == AGM_MODE_REGOFS && xr_ptr_sel != 4'h9 |=> req_error; endproperty
  a_midx: assert property (p_midx) else $error("mac index accepted");
  property p_yodd; yr_addr_valid |-> !yr_addr[0]; endproperty
  a_yodd: assert property (p_yodd) else $error("y address odd");
  c_post: cover property (mcu && xr_mode == AGM_MODE_POST);
  c_yaddr: cover property (yr_addr_valid);
  c_err: cover property (req_error);
endmodule
bind agm_address_generation_modulo agm_checker #(.AW(AW)) u_agm_checker (.*);

// ===== tb/testbench.sv
/*
  self-checking bench: register bus, circular correction in X and Y,
  refused requests and reversed-order priority in the X write unit.
  assumes the register model shows pointers one cycle after write-back.
*/
`timescale 1ns/1ps
`define CHK(n, e, s) begin checked++; if ((s) !== (e)) begin errors++; $display("Error %s exp %h got %h", n, e, s); end end
module testbench;
  import agm_pkg::*;
  int errors = 0, checked = 0, cyc = 0, seed = 77, mp, st;
  logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, xw_word = 1, xr_valid = 0, xw_valid = 0, yr_valid = 0;
  logic [31:0] haddr = '0, hwdata = '0, q;
  logic [1:0] htrans = '0;
  logic [2:0] hsize = 3'h2;
  agm_cls_t xr_cls = AGM_CLS_MCU, xw_cls = AGM_CLS_MOVE, yr_cls = AGM_CLS_MAC;
  agm_mode_t xr_mode = AGM_MODE_IND, xw_mode = AGM_MODE_POST, yr_mode = AGM_MODE_IND;
  logic [3:0] xr_ptr_sel = '0, xw_ptr_sel = '0, yr_ptr_sel = '0;
  logic [15:0] xr_ptr = '0, xr_ofs = '0, xw_ptr = '0, xw_ofs = '0, yr_ptr = '0, yr_ofs = '0, nx;
  logic [12:0] xr_file = '0, xw_file = '0;
  logic [7:0] wa[5] = '{AGM_OFS_X_START, AGM_OFS_X_END, AGM_OFS_Y_START, AGM_OFS_Y_END, AGM_OFS_CONTROL};
  logic [15:0] wd[5] = '{16'h1001, 16'h101e, 16'h2000, 16'h200e, 16'hc0a2};
  logic [15:0] we[5] = '{16'h1000, 16'h101f, 16'h2000, 16'h200f, 16'hc0a2};
  wire [31:0] hrdata;
  wire [15:0] xr_addr, xr_wb_data, xw_addr, xw_wb_data, yr_addr, yr_wb_data, xr_rval;
  wire [3:0] xr_wb_sel, xw_wb_sel, yr_wb_sel;
  wire hreadyout, hresp, xr_addr_valid, xr_wb_valid, xw_addr_valid, xw_wb_valid, yr_addr_valid, yr_wb_valid, req_error;
  always #2 hclk = ~hclk;
  agm_address_generation_modulo u_agm_address_generation_modulo (.*, .hready(hreadyout));
  agm_regfile_model u_agm_regfile_model (.*);
  function automatic logic [15:0] circ(int v, s, e);
    if (v > e) v -= e - s + 1;
    else if (v < s) v += e - s + 1;
    return v[15:0];
  endfunction
  // reversed-carry add: reverse both, add, reverse back
  function automatic logic [15:0] rca(logic [15:0] a, b);
    logic [15:0] ra, rb, r;
    ra = {<<{a}};
    rb = {<<{b}};
    r = ra + rb;
    ra = {<<{r}};
    return ra;
  endfunction
  task automatic summarize;
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic bus(logic w, logic [7:0] a, logic [15:0] d);
    @(posedge hclk);
    {hsel, htrans, hwrite, haddr} <= {1'b1, 2'b10, w, 24'h00_0000, a};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    {hsel, htrans, hwdata} <= {1'b0, 2'b00, 16'h0000, d};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask
  // k: 0 refused, 1 address only, 2 address and write-back
  task automatic req(logic u, agm_cls_t c, agm_mode_t m, logic [3:0] s, logic [15:0] p, o, ea, ew, int k);
    logic [33:0] r;
    @(posedge hclk);
    xr_valid <= !u;
    yr_valid <= u;
    xr_cls <= c;
    yr_cls <= c;
    xr_mode <= m;
    yr_mode <= m;
    {xr_ptr_sel, xr_ptr, xr_ofs, yr_ptr_sel, yr_ptr, yr_ofs} <= {s, p, o, s, p, o};
    @(posedge hclk);
    xr_valid <= 1'b0;
    yr_valid <= 1'b0;
    #1;
    r = u ? {yr_addr_valid, yr_addr, yr_wb_valid, yr_wb_data} : {xr_addr_valid, xr_addr, xr_wb_valid, xr_wb_data};
    `CHK("addr_valid", k > 0, r[33])
    `CHK("req_error", k == 0, req_error)
    `CHK("wb_valid", k == 2, r[16])
    if (k > 0) `CHK("addr", ea, r[32:17])
    if (k == 2) `CHK("wb_data", ew, r[15:0])
  endtask
  always @(posedge hclk) begin
    cyc++;
    if (cyc == 5000) begin
      errors++;
      summarize();
    end
  end
  initial begin
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      bus(0, 8'(4 * i), 16'h0000);
      `CHK("reset", (i == 2 || i == 4) ? 32'h0000_0001 : 32'h0000_0000, q)
    end
    // power-of-two buffers, aligned, so both directions are legal
    foreach (wa[i]) begin
      bus(1, wa[i], wd[i]);
      bus(0, wa[i], 16'h0000);
      `CHK("reg", {16'h0000, we[i]}, q)
    end
    mp = 'h1000;
    for (int i = 0; i < 40; i++) begin
      st = 2 * (1 + $unsigned($random(seed)) % 3);
      if ($random(seed) & 1) st = -st;
      nx = circ(mp + st, 'h1000, 'h101f);
      req(0, AGM_CLS_MCU, AGM_MODE_POST, 4'h2, 16'(mp), 16'(st), 16'(mp), nx, 2);
      mp = nx;
      @(posedge hclk);
      #1;
      `CHK("ptr", nx, xr_rval)
    end
    req(0, AGM_CLS_MCU, AGM_MODE_PRE, 4'h2, 16'h1000, 16'hfffc, 16'h101c, 16'h101c, 2);
    req(0, AGM_CLS_MOVE, AGM_MODE_REGOFS, 4'h2, 16'h101c, 16'h0008, 16'h1004, 16'h0000, 1);
    req(0, AGM_CLS_MCU, AGM_MODE_LITOFS, 4'h3, 16'h101c, 16'h0008, 16'h1024, 16'h0000, 1);
    req(0, AGM_CLS_MCU, AGM_MODE_PRE, 4'hf, 16'h0100, 16'hfffe, 16'h00fe, 16'h00fe, 2);
    req(0, AGM_CLS_MOVE, AGM_MODE_REGOFS, 4'hf, 16'h0100, 16'h0020, 16'h0120, 16'h0000, 1);
    xr_file <= 13'h1abc;
    req(0, AGM_CLS_MCU, AGM_MODE_FILE, 4'h0, 16'h0000, 16'h0000, 16'h1abc, 16'h0000, 1);
    req(0, AGM_CLS_MOVE, AGM_MODE_FILE, 4'h0, 16'h0000, 16'hf00c, 16'hf00c, 16'h0000, 1);
    req(0, AGM_CLS_MAC, AGM_MODE_POST, 4'h8, 16'h1000, 16'h0006, 16'h1000, 16'h1006, 2);
    req(0, AGM_CLS_MAC, AGM_MODE_POST, 4'h8, 16'h1000, 16'h0003, 16'h0000, 16'h0000, 0);
    req(0, AGM_CLS_MAC, AGM_MODE_REGOFS, 4'h8, 16'h1000, 16'h0002, 16'h0000, 16'h0000, 0);
    req(0, AGM_CLS_MAC, AGM_MODE_IND, 4'ha, 16'h1000, 16'h0000, 16'h0000, 16'h0000, 0);
    req(1, AGM_CLS_MAC, AGM_MODE_POST, 4'ha, 16'h200e, 16'h0004, 16'h200e, 16'h2002, 2);
    req(1, AGM_CLS_MAC, AGM_MODE_REGOFS, 4'hb, 16'h2000, 16'h0012, 16'h2012, 16'h0000, 1);
    req(1, AGM_CLS_MAC, AGM_MODE_IND, 4'hb, 16'h2005, 16'h0000, 16'h2004, 16'h0000, 1);
    req(1, AGM_CLS_MCU, AGM_MODE_IND, 4'ha, 16'h2000, 16'h0000, 16'h0000, 16'h0000, 0);
    req(1, AGM_CLS_MAC, AGM_MODE_IND, 4'h8, 16'h2000, 16'h0000, 16'h0000, 16'h0000, 0);
    bus(1, AGM_OFS_REV_CTRL, 16'h8800);
    bus(1, AGM_OFS_CONTROL, 16'hc2a2);
    @(posedge hclk);
    {xw_valid, xw_ptr_sel, xw_ptr, xw_ofs} <= {1'b1, 4'h2, 16'h1000, 16'h0002};
    @(posedge hclk);
    xw_valid <= 1'b0;
    #1;
    `CHK("xw_addr", 16'h1000, xw_addr)
    `CHK("xw_wb", rca(16'h1000, 16'h1000), xw_wb_data)
    req(0, AGM_CLS_MCU, AGM_MODE_POST, 4'h2, 16'h101e, 16'h0004, 16'h101e, 16'h1002, 2);
    for (int i = 0; i < 2; i++) begin
      bus(1, AGM_OFS_CONTROL, i ? 16'h00a2 : 16'hc0ff);
      req(0, AGM_CLS_MCU, AGM_MODE_POST, 4'h2, 16'h101e, 16'h0004, 16'h101e, 16'h1022, 2);
      req(1, AGM_CLS_MAC, AGM_MODE_POST, 4'ha, 16'h200e, 16'h0004, 16'h200e, 16'h2012, 2);
    end
    summarize();
  end
endmodule
